/* File: rtl/vip_pkg.sv */
// How it works
// - Reset: all pins input, wait START
// - Slave address 88H low, 8CH high
// - Three overlay lines index the table
// - Key high picks overlay, else main
// - Table holds eight three-byte entries
// - 27 MHz clock; direction from select
// - Select high receives clock, low generates
// - Qualifier marks valid pixel-rate edges
// - 8-line mode: Cb Y Cr, no codes
// - Request window, then text bits arrive
// - Vertical pin receives or drives field
// - Horizontal pin drives or receives sync
// - Software may mask key on encoder
// - Clock and sync master or slave of pixel port
package vip_pkg;
  localparam logic [7:0] SLAVE_ADDR_LOW = 8'h88;
  localparam logic [7:0] SLAVE_ADDR_HIGH = 8'h8c;
  localparam int LUT_IDX_W = 3;
  localparam int LUT_ENTRIES = 8;
  localparam int BYTE_W = 8;
  localparam int ENTRY_W = 3 * BYTE_W;
  localparam int ENTRY_Y_LSB = 16;
  localparam int ENTRY_CB_LSB = 8;
  localparam int ENTRY_CR_LSB = 0;
  localparam logic [ENTRY_W-1:0] ENTRY_RESET = 24'h108080;
  localparam logic [7:0] BLACK_Y = 8'h10;
  localparam logic [7:0] MID_CHROMA = 8'h80;
  localparam real MASTER_CLK_MHZ = 27.0;
  localparam real PIXEL_CLK_MHZ = 13.5;
  localparam int ACTIVE_PIXELS = 720;
  localparam int ADDR_BITS = 8;
  localparam logic [3:0] ADDR_BITS_CNT = 4'h8;

  typedef enum {PH_CB, PH_Y0, PH_CR, PH_Y1} vip_phase_t;
  typedef enum {I2C_WAIT_START, I2C_ADDR, I2C_HOLD} vip_i2c_t;
endpackage

/* File: rtl/vip_ovl_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface vip_lut_if;
  logic [vip_pkg::LUT_IDX_W-1:0] index;
  logic [vip_pkg::ENTRY_W-1:0] entry;
  logic wrEn;
  logic [vip_pkg::LUT_IDX_W-1:0] wrAddr;
  logic [vip_pkg::ENTRY_W-1:0] wrData;
  modport lut (input index, input wrEn, input wrAddr, input wrData, output entry);
  modport user (output index, output wrEn, output wrAddr, output wrData, input entry);
endinterface
`default_nettype wire

/* File: rtl/vip_overlay_lut.sv */
`timescale 1ns/1ps
`default_nettype none
module vip_overlay_lut (
  input wire logic sys_clk,
  input wire logic rstn,
  vip_lut_if.lut tbl
);
  logic [vip_pkg::ENTRY_W-1:0] table_r [vip_pkg::LUT_ENTRIES];
  logic [vip_pkg::ENTRY_W-1:0] entry_r;

  // Eight entries of three bytes, written one whole entry at a time
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < vip_pkg::LUT_ENTRIES; i++)
        table_r[i] <= vip_pkg::ENTRY_RESET;
    end
    else if (tbl.wrEn)
      table_r[tbl.wrAddr] <= tbl.wrData;
  end

  // Registered read: one cycle from index to entry
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      entry_r <= vip_pkg::ENTRY_RESET;
    else
      entry_r <= table_r[tbl.index];
  end

  assign tbl.entry = entry_r;
endmodule // vip_overlay_lut
`default_nettype wire

/* File: rtl/vip_input_port.sv */
`timescale 1ns/1ps
`default_nettype none
module vip_input_port #(
  parameter int LINE_CLKS = 1728,
  parameter int FIELD_LINES = 312,
  parameter logic [10:0] TEXT_REQ_START = 11'h0c8,
  parameter logic [10:0] TEXT_REQ_LEN = 11'h546
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic addressSelectPin,
  output logic [7:0] slaveAddr,
  input wire logic i2cScl,
  input wire logic i2cSda,
  output logic i2cAddrMatch,
  output logic i2cBusy,
  input wire logic [2:0] overlayIndex,
  input wire logic overlayKey,
  input wire logic encKeyEnable,
  input wire logic lutWrEn,
  input wire logic [2:0] lutWrAddr,
  input wire logic [23:0] lutWrData,
  input wire logic clockDirectionSel,
  output logic masterClockOe,
  input wire logic clockQualifierIn,
  output logic clockQualifierOut,
  output logic clockQualifierOe,
  input wire logic wideMode,
  input wire logic [7:0] mainPixelPort,
  input wire logic [7:0] auxChromaPort,
  output logic [7:0] encY,
  output logic [7:0] encCb,
  output logic [7:0] encCr,
  output logic [7:0] rgbY,
  output logic [7:0] rgbCb,
  output logic [7:0] rgbCr,
  output logic pixelValid,
  input wire logic syncSlave,
  input wire logic syncDriveEn,
  input wire logic [7:0] hsyncLen,
  input wire logic horizontalRasterIn,
  output logic horizontalRasterOut,
  output logic horizontalRasterOe,
  input wire logic verticalRasterIn,
  output logic verticalRasterOut,
  output logic verticalRasterOe,
  output logic textRequest,
  input wire logic textBitstreamIn,
  output logic textBit,
  output logic textBitValid,
  input wire logic realtimeCtlIn,
  output logic realtimeCtl
);
  // ----------------------------------------------------------------
  // Overlay table
  // ----------------------------------------------------------------
  vip_lut_if lutBus ();
  assign lutBus.index = overlayIndex;
  assign lutBus.wrEn = lutWrEn;
  assign lutBus.wrAddr = lutWrAddr;
  assign lutBus.wrData = lutWrData;

  vip_overlay_lut uLut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tbl(lutBus.lut)
  );

  function automatic logic [7:0] pick(input logic key, input logic [7:0] lutByte,
                                      input logic [7:0] mainByte);
    pick = key ? lutByte : mainByte;
  endfunction

  // ----------------------------------------------------------------
  // Clock direction, qualifier, address
  // ----------------------------------------------------------------
  logic qualGen_r;
  logic sampleEn;

  // Pins stay inputs under reset; drivers only turn on afterwards
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      masterClockOe <= 1'b0;
      clockQualifierOe <= 1'b0;
      qualGen_r <= 1'b0;
      slaveAddr <= vip_pkg::SLAVE_ADDR_LOW;
      realtimeCtl <= 1'b0;
    end
    else
    begin
      masterClockOe <= !clockDirectionSel;
      clockQualifierOe <= !clockDirectionSel;
      qualGen_r <= !qualGen_r;
      slaveAddr <= addressSelectPin ? vip_pkg::SLAVE_ADDR_HIGH
                                    : vip_pkg::SLAVE_ADDR_LOW;
      realtimeCtl <= realtimeCtlIn;
    end
  end
  assign clockQualifierOut = qualGen_r;
  // Own qualifier halves the master rate to the pixel rate
  assign sampleEn = clockDirectionSel ? clockQualifierIn : qualGen_r;

  // ----------------------------------------------------------------
  // Raster timing
  // ----------------------------------------------------------------
  logic [10:0] hCount_r;
  logic [9:0] lineCount_r;
  logic hsInPrev_r;
  logic lineStart;
  logic field_r;

  assign lineStart = syncSlave ? (horizontalRasterIn && !hsInPrev_r)
                               : (hCount_r == 11'(LINE_CLKS - 1));

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hCount_r <= '0;
      lineCount_r <= '0;
      hsInPrev_r <= 1'b0;
      field_r <= 1'b0;
    end
    else
    begin
      hsInPrev_r <= horizontalRasterIn;
      if (lineStart)
      begin
        hCount_r <= '0;
        if (lineCount_r == 10'(FIELD_LINES - 1))
        begin
          lineCount_r <= '0;
          field_r <= !field_r;
        end
        else
          lineCount_r <= lineCount_r + 10'h001;
      end
      else
        hCount_r <= hCount_r + 11'h001;
      // A slave field follows the vertical pin
      if (syncSlave)
        field_r <= verticalRasterIn;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      horizontalRasterOe <= 1'b0;
      verticalRasterOe <= 1'b0;
      horizontalRasterOut <= 1'b0;
      verticalRasterOut <= 1'b0;
    end
    else
    begin
      horizontalRasterOe <= syncDriveEn && !syncSlave;
      verticalRasterOe <= syncDriveEn && !syncSlave;
      horizontalRasterOut <= (hCount_r < {3'h0, hsyncLen});
      verticalRasterOut <= field_r;
    end
  end

  // ----------------------------------------------------------------
  // Teletext request and capture
  // ----------------------------------------------------------------
  logic textWin;
  assign textWin = (hCount_r >= TEXT_REQ_START) &&
                   (hCount_r < TEXT_REQ_START + TEXT_REQ_LEN);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      textRequest <= 1'b0;
      textBit <= 1'b0;
      textBitValid <= 1'b0;
    end
    else
    begin
      textRequest <= textWin;
      // Bits are taken only while the request stood the cycle before
      textBitValid <= textRequest;
      textBit <= textRequest ? textBitstreamIn : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pixel demultiplexer
  // ----------------------------------------------------------------
  vip_pkg::vip_phase_t phase_r;
  logic [7:0] yS_r;
  logic [7:0] cbS_r;
  logic [7:0] crS_r;
  logic yNew_r;
  logic keyS_r;

  // Timing codes in the stream are not looked for; they pass as data
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r <= vip_pkg::PH_CB;
      yS_r <= vip_pkg::BLACK_Y;
      cbS_r <= vip_pkg::MID_CHROMA;
      crS_r <= vip_pkg::MID_CHROMA;
      yNew_r <= 1'b0;
    end
    else if (lineStart)
    begin
      phase_r <= vip_pkg::PH_CB;
      yNew_r <= 1'b0;
    end
    else if (sampleEn)
    begin
      yNew_r <= 1'b0;
      case (phase_r)
        vip_pkg::PH_CB:
        begin
          if (wideMode)
          begin
            cbS_r <= auxChromaPort;
            yS_r <= mainPixelPort;
            yNew_r <= 1'b1;
            phase_r <= vip_pkg::PH_CR;
          end
          else
          begin
            cbS_r <= mainPixelPort;
            phase_r <= vip_pkg::PH_Y0;
          end
        end
        vip_pkg::PH_Y0:
        begin
          yS_r <= mainPixelPort;
          yNew_r <= 1'b1;
          phase_r <= vip_pkg::PH_CR;
        end
        vip_pkg::PH_CR:
        begin
          if (wideMode)
          begin
            crS_r <= auxChromaPort;
            yS_r <= mainPixelPort;
            yNew_r <= 1'b1;
            phase_r <= vip_pkg::PH_CB;
          end
          else
          begin
            crS_r <= mainPixelPort;
            phase_r <= vip_pkg::PH_Y1;
          end
        end
        vip_pkg::PH_Y1:
        begin
          yS_r <= mainPixelPort;
          yNew_r <= 1'b1;
          phase_r <= vip_pkg::PH_CB;
        end
        default: phase_r <= vip_pkg::PH_CB;
      endcase
    end
    else
      yNew_r <= 1'b0;
  end

  // Key is delayed one cycle to line up with the registered table read
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      keyS_r <= 1'b0;
    else
      keyS_r <= overlayKey;
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  logic [7:0] lutY;
  logic [7:0] lutCb;
  logic [7:0] lutCr;
  logic encKey;
  assign lutY = lutBus.entry[vip_pkg::ENTRY_Y_LSB +: vip_pkg::BYTE_W];
  assign lutCb = lutBus.entry[vip_pkg::ENTRY_CB_LSB +: vip_pkg::BYTE_W];
  assign lutCr = lutBus.entry[vip_pkg::ENTRY_CR_LSB +: vip_pkg::BYTE_W];
  assign encKey = keyS_r && encKeyEnable;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      encY <= vip_pkg::BLACK_Y;
      encCb <= vip_pkg::MID_CHROMA;
      encCr <= vip_pkg::MID_CHROMA;
      rgbY <= vip_pkg::BLACK_Y;
      rgbCb <= vip_pkg::MID_CHROMA;
      rgbCr <= vip_pkg::MID_CHROMA;
      pixelValid <= 1'b0;
    end
    else
    begin
      encY <= pick(encKey, lutY, yS_r);
      encCb <= pick(encKey, lutCb, cbS_r);
      encCr <= pick(encKey, lutCr, crS_r);
      rgbY <= pick(keyS_r, lutY, yS_r);
      rgbCb <= pick(keyS_r, lutCb, cbS_r);
      rgbCr <= pick(keyS_r, lutCr, crS_r);
      pixelValid <= yNew_r;
    end
  end

  // ----------------------------------------------------------------
  // Serial control receiver: START detect and address compare
  // ----------------------------------------------------------------
  vip_pkg::vip_i2c_t i2cState_r;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic [7:0] addrShift_r;
  logic [3:0] bitCnt_r;
  logic startCond;
  logic stopCond;
  assign startCond = sclPrev_r && i2cScl && sdaPrev_r && !i2cSda;
  assign stopCond = sclPrev_r && i2cScl && !sdaPrev_r && i2cSda;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      i2cState_r <= vip_pkg::I2C_WAIT_START;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      addrShift_r <= '0;
      bitCnt_r <= '0;
      i2cAddrMatch <= 1'b0;
      i2cBusy <= 1'b0;
    end
    else
    begin
      sclPrev_r <= i2cScl;
      sdaPrev_r <= i2cSda;
      if (startCond)
      begin
        i2cState_r <= vip_pkg::I2C_ADDR;
        bitCnt_r <= '0;
        i2cAddrMatch <= 1'b0;
        i2cBusy <= 1'b1;
      end
      else if (stopCond)
      begin
        i2cState_r <= vip_pkg::I2C_WAIT_START;
        i2cAddrMatch <= 1'b0;
        i2cBusy <= 1'b0;
      end
      else
      begin
        case (i2cState_r)
          vip_pkg::I2C_WAIT_START: i2cBusy <= 1'b0;
          vip_pkg::I2C_ADDR:
          begin
            if (!sclPrev_r && i2cScl)
            begin
              addrShift_r <= {addrShift_r[6:0], i2cSda};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
            if (bitCnt_r == vip_pkg::ADDR_BITS_CNT)
            begin
              i2cState_r <= vip_pkg::I2C_HOLD;
              i2cAddrMatch <= (addrShift_r[7:1] == slaveAddr[7:1]);
            end
          end
          vip_pkg::I2C_HOLD: i2cBusy <= 1'b1;
          default: i2cState_r <= vip_pkg::I2C_WAIT_START;
        endcase
      end
    end
  end
endmodule // vip_input_port
`default_nettype wire

/* File: verif/vip_input_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module vip_input_port_assertions (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic addressSelectPin,
  input wire logic [7:0] slaveAddr,
  input wire logic clockDirectionSel,
  input wire logic masterClockOe,
  input wire logic clockQualifierOe,
  input wire logic syncSlave,
  input wire logic horizontalRasterOe,
  input wire logic verticalRasterOe,
  input wire logic textRequest,
  input wire logic textBitValid,
  input wire logic textBit,
  input wire logic realtimeCtlIn,
  input wire logic realtimeCtl,
  input wire logic pixelValid,
  input wire logic overlayKey,
  input wire logic encKeyEnable,
  input wire logic [7:0] encY,
  input wire logic [7:0] encCb,
  input wire logic [7:0] rgbY,
  input wire logic [7:0] rgbCb
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_addr_high: assert property (addressSelectPin |=> slaveAddr == 8'h8c)
    else $error("slave address not 8c");
  a_addr_low: assert property (!addressSelectPin |=> slaveAddr == 8'h88)
    else $error("slave address not 88");
  a_clk_in: assert property (clockDirectionSel |=> !masterClockOe && !clockQualifierOe)
    else $error("clock pins driven while receiving");
  a_clk_out: assert property (!clockDirectionSel |=> masterClockOe && clockQualifierOe)
    else $error("clock pins not driven while generating");
  a_sync_slave: assert property (syncSlave |=> !horizontalRasterOe && !verticalRasterOe)
    else $error("raster pin driven in slave mode");
  a_text_valid: assert property (textRequest |=> textBitValid)
    else $error("text bit not valid after request");
  a_text_quiet: assert property (!textBitValid |-> !textBit)
    else $error("text bit set outside window");
  a_rt_copy: assert property ($rose(realtimeCtlIn) |=> $rose(realtimeCtl))
    else $error("realtime control not passed on");
  a_pv_pulse: assert property (pixelValid |=> !pixelValid)
    else $error("pixel valid longer than one cycle");
  a_key_main: assert property (pixelValid && !$past(overlayKey, 2) |-> encY == rgbY && encCb == rgbCb)
    else $error("main data differs between paths");
  // Key is delayed a cycle in the design, the enable is not
  a_key_ovl: assert property (pixelValid && $past(overlayKey, 2) && $past(encKeyEnable)
    |-> encY == rgbY && encCb == rgbCb)
    else $error("overlay differs between paths");
endmodule // vip_input_port_assertions
`default_nettype wire

/* File: verif/vip_mpeg_source.sv */
`timescale 1ns/1ps
`default_nettype none
module vip_mpeg_source (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic wide,
  output logic qual,
  output logic [7:0] mainByte,
  output logic [7:0] auxByte
);
  // Cb, Y0, Cr, Y1 of one pixel pair, repeated
  localparam logic [31:0] PAIR = 32'h40516273;
  logic [1:0] idx;

  function automatic logic [7:0] pick(input logic [1:0] i);
    return PAIR[31-8*i -: 8];
  endfunction

  initial
  begin
    qual = 1'b0;
    idx = 2'h0;
    mainByte = 8'h00;
    auxByte = 8'h00;
  end

  always @(negedge sys_clk)
  begin
    qual <= run && !qual;
    if (run && !qual)
    begin
      mainByte <= wide ? pick({idx[0], 1'b1}) : pick(idx);
      auxByte <= pick({idx[0], 1'b0});
      idx <= idx + 2'h1;
    end
    else
    begin
      // No stale byte between samples, so a skipped qualifier shows
      mainByte <= ~mainByte;
      auxByte <= ~auxByte;
    end
    if (!run)
      idx <= 2'h0;
  end
endmodule // vip_mpeg_source
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rstn, addressSelectPin, i2cScl, i2cSda, overlayKey, encKeyEnable, lutWrEn;
  logic clockDirectionSel, clockQualifierIn, wideMode, syncSlave, syncDriveEn, run;
  logic horizontalRasterIn, verticalRasterIn, textBitstreamIn, realtimeCtlIn;
  logic [2:0] overlayIndex, lutWrAddr;
  logic [23:0] lutWrData;
  logic [7:0] mainPixelPort, auxChromaPort, hsyncLen, slaveAddr;
  logic [7:0] encY, encCb, encCr, rgbY, rgbCb, rgbCr;
  logic i2cAddrMatch, i2cBusy, masterClockOe, clockQualifierOut, clockQualifierOe, pixelValid;
  logic horizontalRasterOut, horizontalRasterOe, verticalRasterOut, verticalRasterOe;
  logic textRequest, textBit, textBitValid, realtimeCtl;
  int n_mismatch = 0;
  int n_checks = 0;
  localparam logic [7:0] ADDR_88 = 8'h88;

  vip_input_port #(.LINE_CLKS(40), .FIELD_LINES(4), .TEXT_REQ_START(11'h005),
    .TEXT_REQ_LEN(11'h00a)) i_vip_input_port (.sys_clk, .rstn, .addressSelectPin,
    .slaveAddr, .i2cScl, .i2cSda, .i2cAddrMatch, .i2cBusy, .overlayIndex, .overlayKey,
    .encKeyEnable, .lutWrEn, .lutWrAddr, .lutWrData, .clockDirectionSel, .masterClockOe,
    .clockQualifierIn, .clockQualifierOut, .clockQualifierOe, .wideMode, .mainPixelPort,
    .auxChromaPort, .encY, .encCb, .encCr, .rgbY, .rgbCb, .rgbCr, .pixelValid, .syncSlave,
    .syncDriveEn, .hsyncLen, .horizontalRasterIn, .horizontalRasterOut, .horizontalRasterOe,
    .verticalRasterIn, .verticalRasterOut, .verticalRasterOe, .textRequest, .textBitstreamIn,
    .textBit, .textBitValid, .realtimeCtlIn, .realtimeCtl);

  vip_mpeg_source i_src (.sys_clk, .run, .wide(wideMode), .qual(clockQualifierIn),
    .mainByte(mainPixelPort), .auxByte(auxChromaPort));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pixel valid is a one-cycle pulse, so always move on before looking
  task automatic wait_pv;
    int k;
    k = 0;
    do
    begin
      tick(1);
      k++;
    end while (pixelValid !== 1'b1 && k < 60);
    chk(24'(k < 60), 24'h1);
  endtask

  task automatic sbit(input logic s, input logic c);
    i2cSda = s;
    i2cScl = c;
    tick(3);
  endtask

  task automatic start_line(input logic w);
    run <= 1'b0;
    wideMode <= w;
    syncSlave = 1'b1;
    tick(3);
    horizontalRasterIn = 1'b1;
    tick(1);
    horizontalRasterIn = 1'b0;
    tick(4);
    run <= 1'b1;
  endtask

  task automatic test_reset;
    chk(24'({masterClockOe, clockQualifierOe, horizontalRasterOe, verticalRasterOe}), 0);
    chk(24'({slaveAddr, i2cBusy}), 24'h110);
    chk({encY, encCb, encCr}, 24'h108080);
    $display("test_reset done");
  endtask

  task automatic test_clock_dir;
    logic q;
    realtimeCtlIn = 1'b1;
    tick(2);
    chk(24'({masterClockOe, clockQualifierOe, realtimeCtl}), 24'h7);
    q = clockQualifierOut;
    tick(1);
    chk(24'(clockQualifierOut ^ q), 24'h1);
    clockDirectionSel = 1'b1;
    realtimeCtlIn = 1'b0;
    tick(2);
    chk(24'({masterClockOe, clockQualifierOe}), 24'h0);
    $display("test_clock_dir done");
  endtask

  task automatic test_serial;
    for (int p = 0; p < 2; p++)
    begin
      addressSelectPin = p[0];
      sbit(1'b1, 1'b1);
      sbit(1'b0, 1'b1);
      sbit(1'b0, 1'b0);
      for (int i = 7; i >= 0; i--)
      begin
        sbit(ADDR_88[i], 1'b0);
        sbit(ADDR_88[i], 1'b1);
      end
      sbit(1'b0, 1'b0);
      chk(24'({i2cBusy, i2cAddrMatch}), p ? 24'h2 : 24'h3);
      chk(24'(slaveAddr), p ? 24'h8c : 24'h88);
      sbit(1'b0, 1'b1);
      sbit(1'b1, 1'b1);
      chk(24'(i2cBusy), 24'h0);
    end
    $display("test_serial done");
  endtask

  task automatic test_demux;
    for (int w = 0; w < 2; w++)
    begin
      start_line(w[0]);
      wait_pv;
      wait_pv;
      chk({encY, encCb, encCr}, 24'h734062);
      chk({rgbY, rgbCb, rgbCr}, 24'h734062);
    end
    $display("test_demux done");
  endtask

  task automatic test_overlay;
    logic [23:0] e;
    start_line(1'b0);
    lutWrEn = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      lutWrAddr = i[2:0];
      lutWrData = 24'h102030 + 24'(i) * 24'h010101;
      tick(1);
    end
    lutWrEn = 1'b0;
    overlayKey = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      overlayIndex = i[2:0];
      e = 24'h102030 + 24'(i) * 24'h010101;
      wait_pv;
      wait_pv;
      chk({rgbY, rgbCb, rgbCr}, e);
      chk({encY, encCb, encCr}, e);
    end
    encKeyEnable = 1'b0;
    wait_pv;
    wait_pv;
    chk({rgbY, rgbCb, rgbCr}, 24'h102030);
    chk(24'({encCb, encCr}), 24'h4062);
    overlayKey = 1'b0;
    encKeyEnable = 1'b1;
    $display("test_overlay done");
  endtask

  task automatic test_raster;
    int nr, nh, nb;
    logic v;
    run <= 1'b0;
    syncSlave = 1'b0;
    textBitstreamIn = 1'b1;
    // Slave lines left the counter past the line end; it wraps once before lines settle
    tick(2100);
    nr = 0;
    nh = 0;
    nb = 0;
    repeat (40)
    begin
      tick(1);
      nr += int'(textRequest);
      nh += int'(horizontalRasterOut);
      nb += int'(textBit);
    end
    chk(24'(nr), 24'ha);
    chk(24'(nb), 24'ha);
    chk(24'(nh), 24'h3);
    chk(24'({horizontalRasterOe, verticalRasterOe}), 24'h3);
    v = verticalRasterOut;
    tick(160);
    chk(24'(verticalRasterOut ^ v), 24'h1);
    $display("test_raster done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run is about three thousand cycles; allow over three times that
  initial
  begin
    #200000;
    n_mismatch++;
    wrap_up;
  end

  initial
  begin
    {rstn, addressSelectPin, overlayKey, lutWrEn, clockDirectionSel, wideMode, run} = 7'h0;
    {syncSlave, horizontalRasterIn, verticalRasterIn, textBitstreamIn, realtimeCtlIn} = 5'h0;
    {i2cScl, i2cSda, encKeyEnable, syncDriveEn} = 4'hf;
    {overlayIndex, lutWrAddr, lutWrData, hsyncLen} = 38'h3;
    tick(20);
    test_reset;
    rstn = 1'b1;
    test_clock_dir;
    test_serial;
    test_demux;
    test_overlay;
    test_raster;
    wrap_up;
  end
endmodule // testbench

bind vip_input_port vip_input_port_assertions i_vip_input_port_assertions (.sys_clk, .rstn,
  .addressSelectPin, .slaveAddr, .clockDirectionSel, .masterClockOe, .clockQualifierOe,
  .syncSlave, .horizontalRasterOe, .verticalRasterOe, .textRequest, .textBitValid, .textBit,
  .realtimeCtlIn, .realtimeCtl, .pixelValid, .overlayKey, .encKeyEnable, .encY, .encCb,
  .rgbY, .rgbCb);
`default_nettype wire
